// ### pkg/core12_pkg.sv
// core12_pkg: encodings, file addresses, reset values
// and carriers shared by the instruction decoder files.
// assumes nothing of its surroundings.
`default_nettype none

package core12_pkg;

  // ---------------------------------------------------
  // sizes and file addresses
  // ---------------------------------------------------
  localparam int FILE_DEPTH = 32;
  localparam logic [4:0] ADDR_TIMER = 5'h01;
  localparam logic [4:0] ADDR_PCL = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_PORT_B = 5'h06;

  // ---------------------------------------------------
  // status and option bit positions, reset values
  // ---------------------------------------------------
  localparam int ST_CARRY = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PDOWN = 3;
  localparam int ST_TOUT = 4;
  localparam int OPT_PSA = 3;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] DIRECTION_LATCH_LOAD_RESET = 8'hFF;
  localparam logic [8:0] PC_RESET = 9'h000;

  // ---------------------------------------------------
  // opcodes: byte group on ir[11:6]
  // ---------------------------------------------------
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [5:0] OP_MISC = 6'h00;
  localparam logic [5:0] OP_CLR = 6'h01;
  localparam logic [5:0] OP_SUB = 6'h02;
  localparam logic [5:0] OP_DEC = 6'h03;
  localparam logic [5:0] OP_IOR = 6'h04;
  localparam logic [5:0] OP_AND = 6'h05;
  localparam logic [5:0] OP_XOR = 6'h06;
  localparam logic [5:0] OP_ADD = 6'h07;
  localparam logic [5:0] OP_MOVF = 6'h08;
  localparam logic [5:0] OP_COMF = 6'h09;
  localparam logic [5:0] OP_INC = 6'h0A;
  localparam logic [5:0] OP_DECSZ = 6'h0B;
  localparam logic [5:0] OP_RRF = 6'h0C;
  localparam logic [5:0] OP_RLF = 6'h0D;
  localparam logic [5:0] OP_SWAP = 6'h0E;
  localparam logic [5:0] OP_INCSZ = 6'h0F;

  // ---------------------------------------------------
  // opcodes: bit and literal groups on ir[11:8]
  // ---------------------------------------------------
  localparam logic [3:0] OP_BCF = 4'h4;
  localparam logic [3:0] OP_BSF = 4'h5;
  localparam logic [3:0] OP_TEST_SKIP_IF_CLEAR = 4'h6;
  localparam logic [3:0] OP_TEST_SKIP_IF_SET = 4'h7;
  localparam logic [3:0] OP_RETURN_WITH_LITERAL = 4'h8;
  localparam logic [3:0] OP_CALL = 4'h9;
  localparam logic [3:0] OP_UNCONDITIONAL_BRANCH_LO = 4'hA;
  localparam logic [3:0] OP_UNCONDITIONAL_BRANCH_HI = 4'hB;
  localparam logic [3:0] OP_MOVLW = 4'hC;
  localparam logic [3:0] OP_OR_LITERAL_WORK = 4'hD;
  localparam logic [3:0] OP_AND_LITERAL_WORK = 4'hE;
  localparam logic [3:0] OP_XOR_LITERAL_WORK = 4'hF;

  // ---------------------------------------------------
  // fixed words
  // ---------------------------------------------------
  localparam logic [11:0] OP_NOP_WORD = 12'h000;
  localparam logic [11:0] OP_OPTION_WORD = 12'h002;
  localparam logic [11:0] OP_SLEEP_WORD = 12'h003;
  localparam logic [11:0] OP_WATCHDOG_CLEAR_WORD = 12'h004;
  localparam logic [11:0] OP_DIRECTION_LATCH_LOAD_B_WORD = 12'h006;
  localparam logic [11:0] OP_CLEAR_WORKING_WORD = 12'h040;

  // ---------------------------------------------------
  // apb register map
  // ---------------------------------------------------
  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_CORE = 32'h0000_0004;
  localparam logic [31:0] REG_PORT = 32'h0000_0008;
  localparam logic [31:0] REG_INSN = 32'h0000_000C;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_WAKE = 1;

  // ---------------------------------------------------
  // types
  // ---------------------------------------------------
  // four oscillator periods make one instruction cycle
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_e;

  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] oe;
  } pins_s;

  typedef struct packed {
    phase_e phase;
    logic [8:0] pc;
    logic [11:0] ir;
    logic [7:0] w;
    logic [7:0] status;
    logic [7:0] option;
    logic [7:0] direction_latch_load;
    logic [7:0] latch;
    logic [7:0] timer;
    logic [8:0] stack0;
    logic [8:0] stack1;
    logic run;
    logic asleep;
    logic pclr;
    logic wclr;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] pins;
    logic [31:0] rdata;
  } core_state_s;

  localparam core_state_s STATE_RESET = '{
    phase: PH_Q1, pc: PC_RESET, ir: OP_NOP_WORD, w: 8'h00,
    status: STATUS_RESET, option: OPTION_RESET, direction_latch_load: DIRECTION_LATCH_LOAD_RESET,
    latch: 8'h00, timer: 8'h00, stack0: PC_RESET, stack1: PC_RESET,
    run: 1'b0, asleep: 1'b0, pclr: 1'b0, wclr: 1'b0,
    sync1: 8'h00, sync2: 8'h00, sync3: 8'h00, pins: 8'h00,
    rdata: 32'h0000_0000
  };

endpackage : core12_pkg

`default_nettype wire

// ### logic/file_ram.sv
// file_ram: general purpose file registers, one write
// port and one read port whose data leave a register.
// assumes the caller keeps special addresses out of it.
`timescale 1ns/10ps
`default_nettype none

module file_ram (
  // clock
  input wire logic pclk,
  // write port
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [4:0] raddr,
  output logic [7:0] rdata_q
);
  import core12_pkg::*;

  logic [7:0] mem [FILE_DEPTH];

  // no reset: contents are undefined at power-up like real ram
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

endmodule : file_ram

`default_nettype wire

// ### logic/instruction_decoder.sv
// instruction_decoder: fetch, decode and execute for a
// baseline 12-bit instruction set on an 8-bit core.
// assumes an apb master on pclk and a program memory
// that answers prog_addr combinationally on prog_data.
`timescale 1ns/10ps
`default_nettype none

module instruction_decoder (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // program memory
  output logic [8:0] prog_addr,
  input wire logic [11:0] prog_data,
  // port b pins
  input wire logic [7:0] port_b_pin_in,
  output var core12_pkg::pins_s port_b_pins,
  // side effects towards timer, watchdog, power
  output logic prescaler_clear,
  output logic watchdog_clear_pulse,
  output logic standby
);
  import core12_pkg::*;

  // ---------------------------------------------------
  // declarations
  // ---------------------------------------------------
  core_state_s s_q;
  core_state_s s_d;
  logic exec;
  logic mapped;
  logic [5:0] op6;
  logic [4:0] fa;
  logic [7:0] lit;
  logic [7:0] mask;
  logic [7:0] fv;
  logic [7:0] res;
  logic [9:0] sum;
  logic to_file;
  logic to_w;
  logic flush;
  logic set_z;
  logic set_c;
  logic set_dc;
  logic c_v;
  logic dc_v;
  logic [8:0] nxt_pc;
  logic ram_we;
  logic [7:0] ram_rdata;

  // ---------------------------------------------------
  // helpers
  // ---------------------------------------------------
  // returns {carry, digit carry, sum}
  function automatic logic [9:0] add_carries(input logic [7:0] a, input logic [7:0] b,
                                             input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    add_carries = {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction : add_carries

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction : bit_mask

  // one execute slot per four clocks, held off in standby
  assign exec = (s_q.phase == PH_Q4) && s_q.run && !s_q.asleep;
  assign op6 = s_q.ir[11:6];
  assign fa = s_q.ir[4:0];
  assign lit = s_q.ir[7:0];
  assign mask = bit_mask(s_q.ir[7:5]);
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_CORE) ||
                  (paddr == REG_PORT) || (paddr == REG_INSN);

  // ---------------------------------------------------
  // general file registers
  // ---------------------------------------------------
  file_ram u_ram (
    .pclk(pclk),
    .we(ram_we),
    .waddr(fa),
    .wdata(res),
    .raddr(fa),
    .rdata_q(ram_rdata)
  );

  // operand read: the ram answered in the first phase
  always_comb begin
    case (fa)
      ADDR_TIMER: fv = s_q.timer;
      ADDR_PCL: fv = s_q.pc[7:0];
      ADDR_STATUS: fv = s_q.status;
      ADDR_PORT_B: fv = s_q.pins;
      default: fv = ram_rdata;
    endcase
  end

  // ---------------------------------------------------
  // next state
  // ---------------------------------------------------
  always_comb begin
    s_d = s_q;
    res = 8'h00;
    sum = 10'h000;
    to_file = 1'b0;
    to_w = 1'b0;
    flush = 1'b0;
    set_z = 1'b0;
    set_c = 1'b0;
    set_dc = 1'b0;
    c_v = 1'b0;
    dc_v = 1'b0;
    ram_we = 1'b0;
    nxt_pc = s_q.pc + 9'h001;
    s_d.pclr = 1'b0;
    s_d.wclr = 1'b0;

    // pins: a bit moves only when the last two stages agree
    s_d.sync1 = port_b_pin_in;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    s_d.pins = (~(s_q.sync2 ^ s_q.sync3) & s_q.sync2) | ((s_q.sync2 ^ s_q.sync3) & s_q.pins);

    // phase counter, free running
    case (s_q.phase)
      PH_Q1: s_d.phase = PH_Q2;
      PH_Q2: s_d.phase = PH_Q3;
      PH_Q3: s_d.phase = PH_Q4;
      PH_Q4: s_d.phase = PH_Q1;
      default: s_d.phase = PH_Q1;
    endcase

    // apb: read data captured in setup, zero wait states
    if (psel && !penable) begin
      case (paddr)
        REG_CTRL: s_d.rdata = {31'h0000_0000, s_q.run};
        REG_CORE: s_d.rdata = {6'h00, s_q.asleep, s_q.pc, s_q.status, s_q.w};
        REG_PORT: s_d.rdata = {s_q.timer, s_q.option, s_q.direction_latch_load, s_q.latch};
        REG_INSN: s_d.rdata = {20'h0_0000, s_q.ir};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    // wake sits before execute so a standby entry wins
    if (psel && penable && pwrite && (paddr == REG_CTRL) && pstrb[0]) begin
      s_d.run = pwdata[CTRL_RUN];
      if (pwdata[CTRL_WAKE]) begin
        s_d.asleep = 1'b0;
      end
    end

    // ---------------------------------------------------
    // execute
    // ---------------------------------------------------
    if (exec) begin
      if (s_q.ir[11:10] == GRP_BYTE) begin
        to_file = s_q.ir[5];
        to_w = !s_q.ir[5];
        case (op6)
          OP_ADD: begin
            sum = add_carries(s_q.w, fv, 1'b0);
            res = sum[7:0];
            set_c = 1'b1;
            set_dc = 1'b1;
            set_z = 1'b1;
          end
          OP_SUB: begin
            // carry reads as no-borrow
            sum = add_carries(fv, ~s_q.w, 1'b1);
            res = sum[7:0];
            set_c = 1'b1;
            set_dc = 1'b1;
            set_z = 1'b1;
          end
          OP_AND: begin
            res = s_q.w & fv;
            set_z = 1'b1;
          end
          OP_IOR: begin
            res = s_q.w | fv;
            set_z = 1'b1;
          end
          OP_XOR: begin
            res = s_q.w ^ fv;
            set_z = 1'b1;
          end
          OP_INC: begin
            res = fv + 8'h01;
            set_z = 1'b1;
          end
          OP_INCSZ: begin
            res = fv + 8'h01;
            flush = (res == 8'h00);
          end
          OP_DEC: begin
            res = fv - 8'h01;
            set_z = 1'b1;
          end
          OP_DECSZ: begin
            res = fv - 8'h01;
            flush = (res == 8'h00);
          end
          OP_RLF: begin
            res = {fv[6:0], s_q.status[ST_CARRY]};
            sum[9] = fv[7];
            set_c = 1'b1;
          end
          OP_RRF: begin
            res = {s_q.status[ST_CARRY], fv[7:1]};
            sum[9] = fv[0];
            set_c = 1'b1;
          end
          OP_COMF: begin
            res = ~fv;
            set_z = 1'b1;
          end
          OP_MOVF: begin
            res = fv;
            set_z = 1'b1;
          end
          OP_SWAP: begin
            res = {fv[3:0], fv[7:4]};
          end
          OP_CLR: begin
            // clear file when the bit is set, else clear working
            res = 8'h00;
            set_z = 1'b1;
          end
          OP_MISC: begin
            to_w = 1'b0;
            res = s_q.w;
            // move working to file, else the fixed words
            if (!s_q.ir[5]) begin
              case (s_q.ir)
                OP_OPTION_WORD: s_d.option = s_q.w;
                OP_DIRECTION_LATCH_LOAD_B_WORD: s_d.direction_latch_load = s_q.w;
                OP_SLEEP_WORD: begin
                  s_d.asleep = 1'b1;
                  s_d.status[ST_TOUT] = 1'b1;
                  s_d.status[ST_PDOWN] = 1'b0;
                end
                OP_WATCHDOG_CLEAR_WORD: begin
                  s_d.wclr = 1'b1;
                  s_d.status[ST_TOUT] = 1'b1;
                  s_d.status[ST_PDOWN] = 1'b1;
                end
                default: begin
                  res = s_q.w;
                end
              endcase
            end
          end
          default: begin
            to_file = 1'b0;
            to_w = 1'b0;
          end
        endcase
      end else begin
        case (s_q.ir[11:8])
          OP_BCF: begin
            res = fv & ~mask;
            to_file = 1'b1;
          end
          OP_BSF: begin
            res = fv | mask;
            to_file = 1'b1;
          end
          OP_TEST_SKIP_IF_CLEAR: begin
            flush = ((fv & mask) == 8'h00);
          end
          OP_TEST_SKIP_IF_SET: begin
            flush = ((fv & mask) != 8'h00);
          end
          OP_RETURN_WITH_LITERAL: begin
            res = lit;
            to_w = 1'b1;
            nxt_pc = s_q.stack0;
            s_d.stack0 = s_q.stack1;
            flush = 1'b1;
          end
          OP_CALL: begin
            s_d.stack1 = s_q.stack0;
            s_d.stack0 = s_q.pc;
            nxt_pc = {1'b0, lit};
            flush = 1'b1;
          end
          OP_UNCONDITIONAL_BRANCH_LO, OP_UNCONDITIONAL_BRANCH_HI: begin
            // full nine bits: call and pcl writes clear bit eight instead
            nxt_pc = s_q.ir[8:0];
            flush = 1'b1;
          end
          OP_MOVLW: begin
            res = lit;
            to_w = 1'b1;
          end
          OP_OR_LITERAL_WORK: begin
            res = s_q.w | lit;
            to_w = 1'b1;
            set_z = 1'b1;
          end
          OP_AND_LITERAL_WORK: begin
            res = s_q.w & lit;
            to_w = 1'b1;
            set_z = 1'b1;
          end
          OP_XOR_LITERAL_WORK: begin
            res = s_q.w ^ lit;
            to_w = 1'b1;
            set_z = 1'b1;
          end
          default: begin
            res = 8'h00;
          end
        endcase
      end

      // write back
      if (to_w) begin
        s_d.w = res;
      end
      if (to_file) begin
        case (fa)
          ADDR_TIMER: begin
            s_d.timer = res;
            s_d.pclr = !s_q.option[OPT_PSA];
          end
          ADDR_PCL: begin
            nxt_pc = {1'b0, res};
            flush = 1'b1;
          end
          ADDR_STATUS: s_d.status[ST_ZERO:ST_CARRY] = res[2:0];
          ADDR_PORT_B: s_d.latch = res;
          default: ram_we = 1'b1;
        endcase
      end
      // flags last so an instruction's own flags win over a file write
      c_v = sum[9];
      dc_v = sum[8];
      if (set_z) begin
        s_d.status[ST_ZERO] = (res == 8'h00);
      end
      if (set_c) begin
        s_d.status[ST_CARRY] = c_v;
      end
      if (set_dc) begin
        s_d.status[ST_DIGIT] = dc_v;
      end
      s_d.pc = nxt_pc;
      // a taken skip or jump discards the prefetched word
      s_d.ir = flush ? OP_NOP_WORD : prog_data;
    end
  end

  // ---------------------------------------------------
  // state register
  // ---------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prog_addr = s_q.pc;
  assign port_b_pins = '{drive: s_q.latch, oe: ~s_q.direction_latch_load};
  assign prescaler_clear = s_q.pclr;
  assign watchdog_clear_pulse = s_q.wclr;
  assign standby = s_q.asleep;

  // ---------------------------------------------------
  // checks
  // ---------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_exec_spacing: assert property (exec |=> !exec [*3])
    else $error("execute slots closer than four clocks");
  chk_skip_nop: assert property (exec && flush |=> s_q.ir == OP_NOP_WORD)
    else $error("skipped word was not replaced by a no-op");
  chk_call_push: assert property (exec && s_q.ir[11:8] == OP_CALL |=>
      s_q.pc == {1'b0, $past(lit)} && s_q.stack0 == $past(s_q.pc))
    else $error("call target or return address wrong");
  chk_return_lit: assert property (exec && s_q.ir[11:8] == OP_RETURN_WITH_LITERAL |=>
      s_q.w == $past(lit) && s_q.ir == OP_NOP_WORD && !exec ##1 !exec [*2])
    else $error("return did not load literal or take two cycles");
  chk_direction_latch_load_load: assert property (exec && s_q.ir == OP_DIRECTION_LATCH_LOAD_B_WORD |=>
      port_b_pins.oe == ~$past(s_q.w))
    else $error("direction latch not loaded from working");
  chk_standby_flags: assert property (exec && s_q.ir == OP_SLEEP_WORD |=>
      standby && s_q.status[ST_TOUT] && !s_q.status[ST_PDOWN])
    else $error("standby entry flags wrong");
  chk_clear_working_zero: assert property (exec && s_q.ir == OP_CLEAR_WORKING_WORD |=>
      s_q.w == 8'h00 && s_q.status[ST_ZERO])
    else $error("clear working did not set zero");
  chk_and_literal: assert property (exec && s_q.ir[11:8] == OP_AND_LITERAL_WORK |=>
      s_q.w == ($past(s_q.w) & $past(lit)) && s_q.status[ST_ZERO] == (s_q.w == 8'h00)
      && s_q.status[ST_CARRY] == $past(s_q.status[ST_CARRY]))
    else $error("and literal result or flags wrong");
  chk_prescaler_src: assert property (prescaler_clear |->
      $past(exec) && !s_q.option[OPT_PSA] && $past(fa) == ADDR_TIMER)
    else $error("prescaler clear without a timer write");
  chk_pc_bit_eight: assert property (exec && to_file && fa == ADDR_PCL |=>
      !s_q.pc[8] && s_q.ir == OP_NOP_WORD)
    else $error("pc write kept bit eight or did not flush");

endmodule : instruction_decoder

`default_nettype wire

// ### dv/prog_mem_model.sv
// prog_mem_model: program memory in front of the decoder,
// answering each address combinationally with a 12-bit word.
// assumes the bench loads its words before run is set.
`timescale 1ns/10ps
`default_nettype none

module prog_mem_model (
  // fetch side
  input wire logic [8:0] prog_addr,
  output logic [11:0] prog_data
);
  logic [11:0] mem [512];

  // ----------------------------------------------------
  // storage
  // ----------------------------------------------------
  // empty places hold the no-op word, so a runaway pc stays harmless
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 12'h000;
    end
  end

  // one word per 9-bit address, no wait
  assign prog_data = mem[prog_addr];
endmodule : prog_mem_model

`default_nettype wire

// ### dv/instruction_decoder_tb_top.sv
// instruction_decoder_tb_top: apb bench that loads a short
// program, runs it to standby and checks results over apb.
// assumes the program memory model and the core12 package.
`timescale 1ns/10ps
`default_nettype none

module instruction_decoder_tb_top;
  import core12_pkg::*;
  logic pclk, presetn, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, prescaler_clear, watchdog_clear_pulse, standby, err;
  logic [8:0] prog_addr;
  logic [11:0] prog_data;
  logic [7:0] port_b_pin_in;
  pins_s port_b_pins;
  int errors, cmp_count;
  int pclr_n = 0;
  int wclr_n = 0;
  // segment one: skip at word 4 must hide word 5, so w stays zero
  // segment two after wake: pcl jump, option, timer clear, watchdog clear,
  // pin read-modify-write, call and return, subtract, skip, standby
  localparam logic [11:0] PROG [20] = '{12'hC0F, 12'h030, 12'h1D0, 12'hE00,
                                        12'h710, 12'hC55, 12'h006, 12'h003,
                                        12'hC00, 12'h1E2, 12'h002, 12'h061,
                                        12'h004, 12'h206, 12'h526, 12'h920,
                                        12'h090, 12'h690, 12'hC77, 12'h003};

  instruction_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data),
    .port_b_pin_in(port_b_pin_in), .port_b_pins(port_b_pins),
    .prescaler_clear(prescaler_clear), .watchdog_clear_pulse(watchdog_clear_pulse),
    .standby(standby));
  prog_mem_model u_mem (.prog_addr(prog_addr), .prog_data(prog_data));

  // ----------------------------------------------------
  // clock, compare, verdict
  // ----------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // pulse counters for the prescaler and watchdog clear outputs, one count per high cycle
  always @(posedge pclk) begin
    if (prescaler_clear === 1'b1) begin
      pclr_n <= pclr_n + 1;
    end
    if (watchdog_clear_pulse === 1'b1) begin
      wclr_n <= wclr_n + 1;
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------
  // apb master: request held until pready seen at an edge
  // ----------------------------------------------------
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bounded wait on the standby level
  task automatic wait_standby(input logic lvl);
    int n;
    n = 0;
    while (standby !== lvl && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      errors++;
      complete_run();
    end
  endtask : wait_standby

  // ----------------------------------------------------
  // main sequence
  // ----------------------------------------------------
  initial begin
    errors = 0;
    cmp_count = 0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    port_b_pin_in = 8'hA5;
    repeat (12) @(posedge pclk);
    // load only now: the model fills itself with no-ops at time zero
    for (int i = 0; i < 20; i++) begin
      u_mem.mem[i] = PROG[i];
    end
    u_mem.mem[32] = 12'h83C; // subroutine: return with 3C
    presetn <= 1'b1;
    // reset values of core and port words
    apb(1'b0, REG_CORE, 32'h0);
    check("core_reset", rd, 32'h0000_1800);
    apb(1'b0, REG_PORT, 32'h0);
    check("port_reset", rd, 32'h00FF_FF00);
    // unmapped place answers with an error and zero
    apb(1'b0, 32'h0000_0010, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    // run the program to its standby word
    apb(1'b1, REG_CTRL, 32'h1);
    wait_standby(1'b1);
    check("standby", {31'h0, standby}, 32'h1);
    apb(1'b0, REG_CORE, 32'h0);
    check("w_after_skip", {24'h00_0000, rd[7:0]}, 32'h00);
    check("status", {24'h00_0000, rd[15:8]}, 32'h16);
    apb(1'b0, REG_PORT, 32'h0);
    check("direction", {24'h00_0000, rd[15:8]}, 32'h00);
    check("pin_enable", {24'h00_0000, port_b_pins.oe}, 32'hFF);
    apb(1'b0, REG_INSN, 32'h0);
    check("prefetched", rd, 32'h0000_0C00);
    // wake bit releases standby, segment two runs to its own standby
    apb(1'b1, REG_CTRL, 32'h3);
    wait_standby(1'b0);
    check("woken", {31'h0, standby}, 32'h0);
    wait_standby(1'b1);
    // w D3, carry 0 and digit carry 1 from 0F minus 3C, pc 15 after standby
    apb(1'b0, REG_CORE, 32'h0);
    check("core_two", rd, 32'h0215_12D3);
    apb(1'b0, REG_PORT, 32'h0);
    check("port_two", rd, 32'h0000_00A7);
    check("pin_drive", {24'h00_0000, port_b_pins.drive}, 32'hA7);
    check("prescaler_pulses", pclr_n, 32'h1);
    check("watchdog_pulses", wclr_n, 32'h1);
    complete_run();
  end
endmodule : instruction_decoder_tb_top

`default_nettype wire
